// [hw/digitizer_hid_report_framer.sv]
// Overview of operation
// - Touch reports go out on endpoint 3
// - Report is ID 0x01, five slots, count
// - Unused slot bytes are all zero
// - Over five touches, send further consecutive reports
// - Only the first report carries the count
// - Slot header: ID, reserved zero, detect
// - Touch IDs start at one
// - X, Y 12-bit, low byte first
// - Slot bytes nine, ten: width, height
// - Bytes 56, 57: 10 kHz timestamp
// - Byte 58 holds the contact count
// - Stylus reports start with ID 0x03
// - Stylus flags: tip, barrel, eraser, range
// - Stylus X, X center, Y, Y center
// - Stylus byte ten is tip pressure
// - Any contact change sends a report
// - Idle resend, Set Idle, default 8 ms

// ----------------------------------------------------------
// Contact FIFO
// ----------------------------------------------------------
module contact_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH]; // Storage, no reset needed
	logic [AW:0] wr_r; // Write pointer with wrap bit
	logic [AW:0] rd_r; // Read pointer with wrap bit
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);

	assign in_ready = !full;
	assign out_valid = wr_r != rd_r;
	assign out_data = mem_r[rd_r[AW-1:0]];

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_r[AW-1:0]] <= in_data;
	end

	// Pointers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			wr_r <= wr_r + (AW+1)'(push);
			rd_r <= rd_r + (AW+1)'(pop);
		end
	end
endmodule : contact_fifo

// ----------------------------------------------------------
// Report framer
// ----------------------------------------------------------
module digitizer_hid_report_framer #(
	parameter int IDLE_UNIT_CYCLES = framer_pkg::IDLE_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire framer_pkg::contact_type contact_in,
	input wire logic contact_valid,
	output logic contact_ready,
	input wire framer_pkg::pen_type pen_in,
	input wire logic pen_valid,
	input wire logic idle_set,
	input wire logic [7:0] idle_value,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic tx_last,
	output logic [3:0] tx_ep
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------
	// Contact buffer
	// ----------------------------------------------------------
	framer_pkg::contact_type frec; // Contact at FIFO head
	logic fvalid; // FIFO holds a contact
	logic pop; // Take the head contact
	contact_fifo #(
		.WIDTH($bits(framer_pkg::contact_type)),
		.DEPTH(framer_pkg::FIFO_DEPTH)
	) contact_fifo_i (
		.clk(clk),
		.nrst(nrst),
		.in_data(contact_in),
		.in_valid(contact_valid),
		.in_ready(contact_ready),
		.out_data(frec),
		.out_valid(fvalid),
		.out_ready(pop)
	);

	// ----------------------------------------------------------
	// State
	// ----------------------------------------------------------
	framer_pkg::state_type state_r; // Framer state
	framer_pkg::contact_type tbl_r [framer_pkg::MAX_CONTACTS]; // Last scan
	framer_pkg::pen_type pen_r; // Latest stylus sample
	logic pen_pend_r; // Stylus report owed
	logic [4:0] total_r; // Contacts in the last scan
	logic [4:0] fill_r; // Contacts taken of the scan in progress
	logic chg_r; // Scan in progress differs so far
	logic ctrl_en_r; // Framer enabled
	logic [7:0] idle_rate_r; // Idle rate in 4 ms steps
	logic [31:0] unit_cnt_r; // Cycles within an idle step
	logic [7:0] idle_units_r; // Idle steps since the last touch sequence began
	logic [15:0] ts_div_r; // Scan time divider
	logic [15:0] ts_r; // Free scan time
	logic [15:0] ts_lat_r; // Scan time of the report being sent
	logic [1:0] rep_r; // Report index within a sequence
	logic [5:0] byte_r; // Next byte index
	logic [2:0] slot_r; // Slot of the next byte
	logic [3:0] off_r; // Offset within the slot
	logic [15:0] sent_r; // Reports sent
	logic [7:0] tx_data_r;
	logic tx_valid_r;
	logic tx_last_r;
	logic [31:0] prdata_r;
	// Checking aids describing the byte on the output
	logic [5:0] tx_idx_r;
	logic tx_pen_r;
	logic tx_act_r;
	logic [3:0] tx_off_r;
	logic [1:0] tx_rep_r;
	logic tx_more_r;

	// ----------------------------------------------------------
	// Scan collection and change detection
	// ----------------------------------------------------------
	wire collect = (state_r == framer_pkg::COLLECT) && ctrl_en_r;
	wire idle_due = (idle_rate_r != 8'h00) && (idle_units_r >= idle_rate_r);
	wire pen_go = collect && (fill_r == 5'd0) && pen_pend_r;
	assign pop = collect && fvalid && !pen_go;
	wire room = fill_r < 5'(framer_pkg::MAX_CONTACTS);
	wire [4:0] fill_nxt = room ? fill_r + 5'd1 : fill_r;
	wire differ = (fill_r >= total_r) || (frec != tbl_r[fill_r[3:0]]);
	wire scan_chg = chg_r || differ || (fill_nxt != total_r);
	wire scan_go = pop && frec.last && scan_chg;
	wire idle_go = collect && (fill_r == 5'd0) && !pen_pend_r && !fvalid && idle_due;
	wire touch_go = scan_go || idle_go;

	// Scan table, overwritten in place; old entries serve the compare
	always_ff @(posedge clk)
	begin
		if (pop && room)
			tbl_r[fill_r[3:0]] <= frec;
	end

	// Scan bookkeeping
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			fill_r <= 5'd0;
			total_r <= 5'd0;
			chg_r <= 1'b0;
		end
		else if (pop && frec.last)
		begin
			fill_r <= 5'd0;
			total_r <= fill_nxt;
			chg_r <= 1'b0;
		end
		else if (pop)
		begin
			fill_r <= fill_nxt;
			chg_r <= chg_r || differ;
		end
	end

	// Stylus sample; a new sample wins over the clear of the old one
	always_ff @(posedge clk)
	begin
		if (!nrst)
			pen_pend_r <= 1'b0;
		else if (pen_valid)
			pen_pend_r <= 1'b1;
		else if (pen_go)
			pen_pend_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (pen_valid)
			pen_r <= pen_in;
	end

	// ----------------------------------------------------------
	// Scan time and idle interval
	// ----------------------------------------------------------
	// Scan time ticks at 10 kHz
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ts_div_r <= 16'h0000;
			ts_r <= 16'h0000;
		end
		else if (ts_div_r == 16'(framer_pkg::TS_CYCLES - 1))
		begin
			ts_div_r <= 16'h0000;
			ts_r <= ts_r + 16'h0001;
		end
		else
			ts_div_r <= ts_div_r + 16'h0001;
	end

	// Idle steps restart at the first report of each touch sequence and on a new rate
	wire idle_wr = idle_set || (psel && penable && pwrite && (paddr == framer_pkg::IDLE_OFS));
	wire [7:0] idle_val = idle_set ? idle_value : pwdata[7:0];
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			idle_rate_r <= framer_pkg::IDLE_DEFAULT;
			unit_cnt_r <= 32'h0000_0000;
			idle_units_r <= 8'h00;
		end
		else if (idle_wr || touch_go)
		begin
			if (idle_wr)
				idle_rate_r <= idle_val;
			unit_cnt_r <= 32'h0000_0000;
			idle_units_r <= 8'h00;
		end
		else if (unit_cnt_r == 32'(IDLE_UNIT_CYCLES - 1))
		begin
			unit_cnt_r <= 32'h0000_0000;
			if (idle_units_r != 8'hFF)
				idle_units_r <= idle_units_r + 8'h01;
		end
		else
			unit_cnt_r <= unit_cnt_r + 32'h0000_0001;
	end

	// ----------------------------------------------------------
	// Byte builder
	// ----------------------------------------------------------
	wire [4:0] cidx = 5'(int'(rep_r) * framer_pkg::SLOTS + int'(slot_r));
	framer_pkg::contact_type crec;
	assign crec = tbl_r[cidx[3:0]];
	wire active = (cidx < total_r) && (byte_r != 6'h00) && (byte_r <= framer_pkg::SLOT_END_BYTE);

	// One slot byte of an active contact
	function automatic logic [7:0] slot_byte(input framer_pkg::contact_type c, input logic [3:0] o);
		logic [4:0] id1;
		id1 = c.id + 5'd1;
		case (o)
			4'h0: slot_byte = {id1, 2'b00, c.detect};
			4'h1, 4'h3: slot_byte = c.x[7:0];
			4'h2, 4'h4: slot_byte = {4'h0, c.x[11:8]};
			4'h5, 4'h7: slot_byte = c.y[7:0];
			4'h6, 4'h8: slot_byte = {4'h0, c.y[11:8]};
			4'h9: slot_byte = c.w;
			default: slot_byte = c.h;
		endcase
	endfunction : slot_byte

	// One stylus report byte
	function automatic logic [7:0] pen_byte(input framer_pkg::pen_type p, input logic [5:0] b);
		case (b)
			6'h00: pen_byte = framer_pkg::PEN_RID;
			6'h01: pen_byte = {3'b000, p.in_range, 1'b0, p.eraser, p.barrel, p.tip};
			6'h02: pen_byte = p.x[7:0];
			6'h03: pen_byte = p.x[15:8];
			6'h04: pen_byte = p.xc[7:0];
			6'h05: pen_byte = p.xc[15:8];
			6'h06: pen_byte = p.y[7:0];
			6'h07: pen_byte = p.y[15:8];
			6'h08: pen_byte = p.yc[7:0];
			6'h09: pen_byte = p.yc[15:8];
			default: pen_byte = p.pressure;
		endcase
	endfunction : pen_byte

	wire is_pen = state_r == framer_pkg::SEND_PEN;
	wire [7:0] touch_val = (byte_r == 6'h00) ? framer_pkg::TOUCH_RID :
		active ? slot_byte(crec, off_r) :
		(byte_r == framer_pkg::TS_LO_BYTE) ? ts_lat_r[7:0] :
		(byte_r == framer_pkg::TS_HI_BYTE) ? ts_lat_r[15:8] :
		(byte_r == framer_pkg::COUNT_BYTE && rep_r == 2'd0) ? {3'b000, total_r} :
		8'h00;
	wire [7:0] byte_val = is_pen ? pen_byte(pen_r, byte_r) : touch_val;
	wire rep_end = is_pen ? (byte_r == framer_pkg::PEN_LAST_BYTE) : (byte_r == framer_pkg::COUNT_BYTE);
	wire more = 32'(int'(rep_r) * framer_pkg::SLOTS + framer_pkg::SLOTS) < 32'(total_r);
	wire sending = (state_r == framer_pkg::SEND_TOUCH) || is_pen;
	wire step = sending && (!tx_valid_r || tx_ready);
	wire in_slots = (byte_r != 6'h00) && (byte_r <= framer_pkg::SLOT_END_BYTE);

	// ----------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r <= framer_pkg::COLLECT;
			rep_r <= 2'd0;
			byte_r <= 6'h00;
			slot_r <= 3'd0;
			off_r <= 4'h0;
		end
		else
		begin
			case (state_r)
				framer_pkg::COLLECT:
				begin
					// Stylus reports never split a touch sequence
					if (pen_go)
						state_r <= framer_pkg::SEND_PEN;
					else if (touch_go)
						state_r <= framer_pkg::SEND_TOUCH;
				end
				default:
				begin
					if (step && rep_end)
					begin
						byte_r <= 6'h00;
						slot_r <= 3'd0;
						off_r <= 4'h0;
						// Remaining touches follow at once
						if (!is_pen && more)
							rep_r <= rep_r + 2'd1;
						else
						begin
							rep_r <= 2'd0;
							state_r <= framer_pkg::COLLECT;
						end
					end
					else if (step)
					begin
						byte_r <= byte_r + 6'h01;
						if (in_slots && off_r == framer_pkg::SLOT_LAST)
						begin
							off_r <= 4'h0;
							slot_r <= slot_r + 3'd1;
						end
						else if (in_slots)
							off_r <= off_r + 4'h1;
					end
				end
			endcase
		end
	end

	// Scan time is frozen at the identifier byte of each report
	always_ff @(posedge clk)
	begin
		if (!nrst)
			ts_lat_r <= 16'h0000;
		else if (step && byte_r == 6'h00)
			ts_lat_r <= ts_r;
	end

	// ----------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			tx_data_r <= 8'h00;
			tx_valid_r <= 1'b0;
			tx_last_r <= 1'b0;
			tx_idx_r <= 6'h00;
			tx_pen_r <= 1'b0;
			tx_act_r <= 1'b0;
			tx_off_r <= 4'h0;
			tx_rep_r <= 2'd0;
			tx_more_r <= 1'b0;
		end
		else if (step)
		begin
			tx_data_r <= byte_val;
			tx_valid_r <= 1'b1;
			tx_last_r <= rep_end;
			tx_idx_r <= byte_r;
			tx_pen_r <= is_pen;
			tx_act_r <= active && !is_pen;
			tx_off_r <= off_r;
			tx_rep_r <= rep_r;
			tx_more_r <= !is_pen && more;
		end
		else if (tx_ready)
			tx_valid_r <= 1'b0;
	end

	// Report tally
	always_ff @(posedge clk)
	begin
		if (!nrst)
			sent_r <= 16'h0000;
		else if (step && rep_end)
			sent_r <= sent_r + 16'h0001;
	end

	assign tx_data = tx_data_r;
	assign tx_valid = tx_valid_r;
	assign tx_last = tx_last_r;
	assign tx_ep = framer_pkg::TOUCH_EP;

	// ----------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------
	wire hit_ctrl = paddr == framer_pkg::CTRL_OFS;
	wire hit_idle = paddr == framer_pkg::IDLE_OFS;
	wire hit_stat = paddr == framer_pkg::STATUS_OFS;
	wire hit_rep = paddr == framer_pkg::REPORTS_OFS;
	wire hit = hit_ctrl || hit_idle || hit_stat || hit_rep;
	wire [31:0] rd_val = hit_ctrl ? {31'h0, ctrl_en_r} :
		hit_idle ? {24'h00_0000, idle_rate_r} :
		hit_stat ? {16'h0000, 3'b000, total_r, 6'h00, pen_pend_r, sending} :
		hit_rep ? {16'h0000, sent_r} : 32'h0000_0000;

	// Read data is caught in the setup cycle
	always_ff @(posedge clk)
	begin
		if (!nrst)
			prdata_r <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_r <= rd_val;
	end

	// Enable; while off, the FIFO fills and stalls the source
	always_ff @(posedge clk)
	begin
		if (!nrst)
			ctrl_en_r <= framer_pkg::CTRL_RESET;
		else if (psel && penable && pwrite && hit_ctrl)
			ctrl_en_r <= pwdata[framer_pkg::CTRL_EN_BIT];
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	AST_TOUCH_RID: assert property (tx_valid && !tx_pen_r && tx_idx_r == 6'h00 |-> tx_data == 8'h01)
		else $error("touch report id wrong");
	AST_TOUCH_LEN: assert property (tx_valid && tx_last && !tx_pen_r |-> tx_idx_r == 6'h3A)
		else $error("touch report length wrong");
	AST_ZERO_SLOT: assert property (tx_valid && !tx_pen_r && !tx_act_r && tx_idx_r != 6'h00
		&& tx_idx_r <= 6'h37 |-> tx_data == 8'h00)
		else $error("unused slot byte not zero");
	AST_LATER_COUNT: assert property (tx_valid && !tx_pen_r && tx_idx_r == 6'h3A && tx_rep_r != 2'd0
		|-> tx_data == 8'h00)
		else $error("later count byte not zero");
	AST_SLOT_HDR: assert property (tx_valid && tx_act_r && tx_off_r == 4'h0
		|-> tx_data[2:1] == 2'b00 && tx_data[7:3] != 5'd0)
		else $error("slot header malformed");
	AST_MSB_ZERO: assert property (tx_valid && tx_act_r && tx_off_r inside {4'h2, 4'h4, 4'h6, 4'h8}
		|-> tx_data[7:4] == 4'h0)
		else $error("coordinate high nibble set");
	AST_NEXT_REPORT: assert property (tx_valid && tx_ready && tx_last && tx_more_r
		|-> ##[1:2] tx_valid && !tx_pen_r && tx_idx_r == 6'h00)
		else $error("follow-on report missing");
	AST_PEN_HDR: assert property (tx_valid && tx_pen_r && tx_idx_r == 6'h00 ##1 tx_valid && tx_pen_r
		&& tx_idx_r == 6'h01 |-> tx_data[7:5] == 3'b000 && !tx_data[3] && $past(tx_data) == 8'h03)
		else $error("stylus header malformed");
	AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("output byte dropped under stall");
	AST_IDLE_DEF: assert property ($fell(!nrst) |=> idle_rate_r == 8'h02)
		else $error("idle default wrong");
	COV_MULTI: cover property (tx_valid && tx_last && tx_more_r);
	COV_PEN: cover property (tx_valid && tx_pen_r && tx_last);
	COV_IDLE: cover property (idle_go);
	COV_FULL: cover property (contact_valid && !contact_ready);
endmodule : digitizer_hid_report_framer

// [pkg/framer_pkg.sv]
package framer_pkg;
	// ----------------------------------------------------------
	// Timing
	// ----------------------------------------------------------
	localparam int CLK_HZ = 20_000_000; // System clock rate
	localparam int TS_HZ = 10_000; // Scan time resolution
	localparam int TS_CYCLES = CLK_HZ / TS_HZ; // Cycles per scan time tick
	localparam int IDLE_UNIT_MS = 4; // One idle step of Set Idle
	localparam int IDLE_UNIT_CYCLES = (CLK_HZ / 1000) * IDLE_UNIT_MS; // Cycles per idle step
	localparam logic [7:0] IDLE_DEFAULT = 8'h02; // Idle rate after reset, 8 ms

	// ----------------------------------------------------------
	// Report layout
	// ----------------------------------------------------------
	localparam logic [7:0] TOUCH_RID = 8'h01; // Touch report identifier
	localparam logic [7:0] PEN_RID = 8'h03; // Stylus report identifier
	localparam logic [3:0] TOUCH_EP = 4'h3; // Interrupt-IN endpoint number
	localparam int SLOTS = 5; // Touch slots per report
	localparam logic [3:0] SLOT_LAST = 4'hA; // Last byte offset in a slot
	localparam logic [5:0] SLOT_END_BYTE = 6'h37; // Byte 55, last slot byte
	localparam logic [5:0] TS_LO_BYTE = 6'h38; // Byte 56
	localparam logic [5:0] TS_HI_BYTE = 6'h39; // Byte 57
	localparam logic [5:0] COUNT_BYTE = 6'h3A; // Byte 58, last touch byte
	localparam logic [5:0] PEN_LAST_BYTE = 6'h0A; // Byte 10, last stylus byte
	localparam int MAX_CONTACTS = 16; // Contacts held per scan
	localparam int FIFO_DEPTH = 16; // Contact FIFO depth

	// ----------------------------------------------------------
	// Register map
	// ----------------------------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000; // Bit 0 enable
	localparam logic [11:0] IDLE_OFS = 12'h004; // Idle rate, 4 ms steps
	localparam logic [11:0] STATUS_OFS = 12'h008; // Busy, pen pending, count
	localparam logic [11:0] REPORTS_OFS = 12'h00C; // Reports sent
	localparam int CTRL_EN_BIT = 0; // Enable bit position
	localparam logic CTRL_RESET = 1'b1; // Enabled after reset

	// ----------------------------------------------------------
	// Types
	// ----------------------------------------------------------
	typedef struct packed {
		logic last; // Last contact of a scan
		logic [4:0] id; // Tracking index, zero based
		logic detect; // Contact is detected
		logic [11:0] x; // X coordinate
		logic [11:0] y; // Y coordinate
		logic [7:0] w; // Contact width
		logic [7:0] h; // Contact height
	} contact_type;

	typedef struct packed {
		logic tip; // Tip contact
		logic barrel; // Barrel button
		logic eraser; // Eraser active
		logic in_range; // Stylus in range
		logic [15:0] x; // X position
		logic [15:0] xc; // X center position
		logic [15:0] y; // Y position
		logic [15:0] yc; // Y center position
		logic [7:0] pressure; // Tip pressure
	} pen_type;

	typedef enum logic [1:0] {COLLECT, SEND_TOUCH, SEND_PEN} state_type;
endpackage : framer_pkg

// [sim/tb_digitizer_hid_report_framer.sv]
module tb_digitizer_hid_report_framer;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	framer_pkg::contact_type contact_in = '0;
	logic contact_valid = 1'b0;
	logic contact_ready;
	framer_pkg::pen_type pen_in = '0;
	logic pen_valid = 1'b0;
	logic idle_set = 1'b0;
	logic [7:0] idle_value = 8'h00;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic tx_last;
	logic [3:0] tx_ep;
	logic slow = 1'b0; // Host stalls when set
	int n_fail = 0;
	int total_checks = 0;
	logic [31:0] rd; // Last read data
	logic er; // Last error flag
	logic [15:0] ts0; // Scan time of the first report of the long sequence
	logic [8:0] q[$]; // Copy of the host queue

	always #25 clk = ~clk;

	// Short idle step keeps the resend wait at tens of cycles
	digitizer_hid_report_framer #(.IDLE_UNIT_CYCLES(20)) digitizer_hid_report_framer_i (
		.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .contact_in(contact_in),
		.contact_valid(contact_valid), .contact_ready(contact_ready), .pen_in(pen_in), .pen_valid(pen_valid),
		.idle_set(idle_set), .idle_value(idle_value), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_last(tx_last), .tx_ep(tx_ep)
	);
	usb_host_model usb_host_model_i (.clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .slow(slow), .tx_ready(tx_ready));

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Any bounded wait that runs out ends the run as a mismatch
	task automatic give_up(input logic ok);
		if (!ok)
		begin
			n_fail++;
			end_of_test();
		end
	endtask : give_up

	// One APB transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 100 && pready !== 1'b1; i++)
			@(posedge clk);
		give_up(pready === 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let one edge pass so a following call never drives psel twice in a step
		@(posedge clk);
	endtask : apb

	// One scan of n contacts; valid stays up between contacts
	task automatic scan(input int n);
		int k;
		int i;
		for (k = 0; k < n; k++)
		begin
			contact_in <= '{last: (k == n - 1), id: k[4:0], detect: 1'b1, x: 12'h800 + 12'(k),
				y: 12'h400 + 12'(k * 3), w: 8'h10 + k[7:0], h: 8'h30 + k[7:0]};
			contact_valid <= 1'b1;
			@(posedge clk);
			for (i = 0; i < 500 && contact_ready !== 1'b1; i++)
				@(posedge clk);
			give_up(contact_ready === 1'b1);
		end
		contact_valid <= 1'b0;
	endtask : scan

	task automatic wait_rx(input int n);
		int i;
		for (i = 0; i < 3000 && usb_host_model_i.rx.size() < n; i++)
			@(posedge clk);
		give_up(usb_host_model_i.rx.size() >= n);
		q = usb_host_model_i.rx;
	endtask : wait_rx

	task automatic set_idle(input logic [7:0] v);
		idle_value <= v;
		idle_set <= 1'b1;
		@(posedge clk);
		idle_set <= 1'b0;
	endtask : set_idle

	// Touch report at q[b]: n active slots from contact f, count byte cnt
	task automatic chk_report(input int b, input int f, input int n, input logic [7:0] cnt);
		int s;
		int i;
		int k;
		logic [11:0] x;
		logic [11:0] y;
		logic [7:0] e[11];
		chk("report id", 8'h01, q[b][7:0]);
		for (s = 0; s < 5; s++)
		begin
			k = f + s;
			x = 12'h800 + 12'(k);
			y = 12'h400 + 12'(k * 3);
			e = '{{k[4:0] + 5'h01, 3'h1}, x[7:0], {4'h0, x[11:8]}, x[7:0], {4'h0, x[11:8]},
				y[7:0], {4'h0, y[11:8]}, y[7:0], {4'h0, y[11:8]}, 8'h10 + k[7:0], 8'h30 + k[7:0]};
			for (i = 0; i < 11; i++)
				chk("slot byte", (s < n) ? e[i] : 8'h00, q[b + 1 + s * 11 + i]);
		end
		chk("count", {1'b1, cnt}, q[b + 58]);
		chk("early end", 1'b0, q[b + 57][8]);
	endtask : chk_report

	// Stylus report with flag set f
	task automatic pen(input logic [3:0] f);
		int i;
		logic [15:0] v[4];
		v = '{16'h1234 ^ {12'h0, f}, 16'h5678, 16'h9ABC, 16'hDEF0};
		pen_in <= '{tip: f[0], barrel: f[1], eraser: f[2], in_range: f[3], x: v[0], xc: v[1],
			y: v[2], yc: v[3], pressure: 8'h5A};
		pen_valid <= 1'b1;
		@(posedge clk);
		pen_valid <= 1'b0;
		wait_rx(11);
		chk("pen id", 8'h03, q[0]);
		chk("pen flags", {3'h0, f[3], 1'b0, f[2:0]}, q[1]);
		for (i = 0; i < 4; i++)
			chk("pen field", v[i], {q[3 + 2 * i][7:0], q[2 + 2 * i][7:0]});
		chk("pen pressure", 9'h15A, q[10]);
		usb_host_model_i.rx.delete();
	endtask : pen

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, framer_pkg::CTRL_OFS, 32'h0);
		chk("enable after reset", 32'h1, rd);
		chk("no error", 1'b0, er);
		apb(1'b0, framer_pkg::IDLE_OFS, 32'h0);
		chk("idle after reset", 32'h2, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped error", 1'b1, er);
		// Idle off so only changes send reports
		apb(1'b1, framer_pkg::IDLE_OFS, 32'h0);
		apb(1'b0, framer_pkg::IDLE_OFS, 32'h0);
		chk("idle written", 32'h0, rd);
		repeat (300) @(posedge clk);
		usb_host_model_i.rx.delete();
		chk("endpoint", 4'h3, tx_ep);
		// One touch, slow host: one report, 44 zero bytes
		slow <= 1'b1;
		scan(1);
		wait_rx(59);
		chk_report(0, 0, 1, 8'h01);
		usb_host_model_i.rx.delete();
		slow <= 1'b0;
		// Sixteen touches queued while disabled, FIFO fills
		apb(1'b1, framer_pkg::CTRL_OFS, 32'h0);
		scan(16);
		@(posedge clk);
		chk("fifo full", 1'b0, contact_ready);
		apb(1'b1, framer_pkg::CTRL_OFS, 32'h1);
		wait_rx(236);
		ts0 = {q[57][7:0], q[56][7:0]};
		for (int r = 0; r < 4; r++)
			chk_report(r * 59, r * 5, (r < 3) ? 5 : 1, (r == 0) ? 8'h10 : 8'h00);
		chk("scan time step", 1'b1, ({q[116][7:0], q[115][7:0]} - {q[57][7:0], q[56][7:0]}) <= 16'h0001);
		usb_host_model_i.rx.delete();
		// Same scan again: nothing changes, nothing sent
		scan(16);
		// Long quiet spell: no change report, and the scan time must move on
		repeat (2 * framer_pkg::TS_CYCLES) @(posedge clk);
		chk("no report", 32'h0, usb_host_model_i.rx.size());
		apb(1'b0, framer_pkg::STATUS_OFS, 32'h0);
		chk("status", 32'h0000_1000, rd);
		// Idle resend after one step
		set_idle(8'h01);
		wait_rx(59);
		chk("resend id", 9'h001, q[0]);
		chk("resend count", 9'h110, q[58]);
		chk("scan time rate", 1'b1, (({q[57][7:0], q[56][7:0]} - ts0) inside {16'h0002, 16'h0003}));
		set_idle(8'h00);
		repeat (400) @(posedge clk);
		usb_host_model_i.rx.delete();
		pen(4'h5);
		pen(4'hA);
		// One single, two sequences of four, two stylus reports
		apb(1'b0, framer_pkg::REPORTS_OFS, 32'h0);
		chk("reports sent", 32'h0000_000B, rd);
		end_of_test();
	end
endmodule : tb_digitizer_hid_report_framer

// [sim/usb_host_model.sv]
// ----------------------------------------------------------
// Host side of the interrupt-IN report stream
// ----------------------------------------------------------
module usb_host_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic slow,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] rx[$]; // Bytes taken, end flag on top
	logic [1:0] ph = 2'h0; // Stall pattern phase
	// Take a byte on valid and ready; when slow, accept only one cycle in three
	always @(posedge clk)
	begin
		if (nrst && tx_valid && tx_ready)
			rx.push_back({tx_last, tx_data});
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		tx_ready <= !slow || (ph == 2'h0);
	end
endmodule : usb_host_model
